// [design/kpg_regs.svh]
// register offsets, field positions, reset values and timing figures of the
// keypad/gpio configuration block; definitions only.
`ifndef KPG_REGS_SVH
`define KPG_REGS_SVH
`define KPG_OFS_CFG 8'h01
`define KPG_OFS_FLAGS 8'h02
`define KPG_OFS_DIR_ROWS 8'h23
`define KPG_OFS_DIR_CLO 8'h24
`define KPG_OFS_DIR_CHI 8'h25
`define KPG_OFS_POL_ROWS 8'h26
`define KPG_OFS_POL_CLO 8'h27
`define KPG_OFS_POL_CHI 8'h28
`define KPG_OFS_BYP_ROWS 8'h29
`define KPG_OFS_BYP_CHI 8'h2B
`define KPG_OFS_PULL_ROWS 8'h2C
`define KPG_OFS_PULL_CHI 8'h2E
`define KPG_OFS_BYP_CLO 8'h30
`define KPG_OFS_PULL_CLO 8'h3D
`define KPG_CFG_STEP 7
`define KPG_CFG_LOCKSEL 6
`define KPG_CFG_WRAP 5
`define KPG_CFG_REALERT 4
`define KPG_CFG_OVR_EN 3
`define KPG_CFG_LOCK_EN 2
`define KPG_FLG_CAD 4
`define KPG_FLG_OVR 3
`define KPG_FLG_LOCK 2
`define KPG_FLG_GPI 1
`define KPG_FLG_KEY 0
`define KPG_CFG_RST 8'h00
`define KPG_FLG_RST 5'h00
`define KPG_BANK_RST 18'h00000
`define KPG_GPI_CODE_BASE 7'h61
`define KPG_CLK_NS 25
`define KPG_DEB_NS 50000
`define KPG_SCAN_NS 25000000
`define KPG_DEB_CYC ((`KPG_DEB_NS + `KPG_CLK_NS - 1) / `KPG_CLK_NS)
`define KPG_SCAN_CYC (`KPG_SCAN_NS / `KPG_CLK_NS)
`endif

// [design/kpg_pkg.sv]
// types shared by the keypad/gpio configuration block.
// assumes kpg_regs.svh supplies the numeric layout.
package kpg_pkg;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_WR, I2C_ACK_W, I2C_RD,
    I2C_RACK} kpg_i2c_t;
  typedef enum logic [2:0] {SC_IDLE, SC_COL, SC_CMP, SC_WALK, SC_WAIT} kpg_scan_t;
  typedef struct packed {
    kpg_i2c_t i2c;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] rsh;
    logic [7:0] ptr;
    logic first;
    logic rw;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic [7:0] cfg;
    logic [4:0] flags;
    logic [17:0] dir;
    logic [17:0] pol;
    logic [17:0] byp;
    logic [17:0] pull;
    logic [17:0] deb;
    logic [17:0][10:0] dcnt;
    logic [10:0] rcnt;
    logic rdeb;
    kpg_scan_t scan;
    logic [23:0] tcnt;
    logic [3:0] col;
    logic [11:0] scnt;
    logic [79:0] cur;
    logic [79:0] prev;
    logic [79:0] acc;
    logic [6:0] widx;
    logic [17:0] gpend;
    logic cad_q;
    logic [10:0] hold;
    logic int_n;
    logic [17:0] pin_oe;
    logic [17:0] pin_out;
    logic [17:0] pull_en;
    logic evt_v;
    logic [7:0] evt_code;
  } kpg_state_t;
endpackage : kpg_pkg

// [design/kpg_top.sv]
// keypad scan / gpio configuration, interrupt flags and i2c register target.
// assumes pin and bus inputs are synchronous to clk_i; the event queue,
// keylock timers and gpio data registers live in neighbouring blocks.
// Contract
// - direction bit 0 makes pin input, 1 output; reset is input
// - polarity 0 triggers on falling/low, 1 on rising/high; default 0
// - filter bypass bit 1 skips debounce for that input; 0 default
// - bypass acts identically on gpio inputs and keypad rows
// - hardware reset input is always debounced for 50 us
// - debounced input changes only after 50 us of stable level
// - columns of the keypad are swept once every 25 ms
// - key accepted only when two full scans agree
// - pull-up-off bit 0 connects pull-up, 1 disconnects; default 0
// - flag bit 4 marks three-key reset; host clears by writing 1
// - flag bit 3 marks queue overrun; cleared by writing 1
// - flag bit 2 set when lock sequence starts; write 1 clears
// - bit 1 input change, bit 0 key events; write 1 clears, bit 0 only while no queue event pending; 7:5 zero
// - overrun alert only when configuration bits 3 and 5 both set
// - configuration bit 7 auto-increments register address on reads and writes
// - configuration bit 6 set ignores input events while locked
// - bit 5 clear drops events when full; set pushes oldest out
// - bit 4 set releases alert 50 us on clear while pending
// - bit 3 enables overrun alert, bit 2 enables lock alert
// - idle columns driven low; row low starts one-column-at-a-time sweep
// - keys 1, 11 and 21 together set the three-key reset flag
// - event codes 7 bits: keys 1..80, inputs 97..114
// - keypad select 1 puts pin in matrix, 0 leaves it gpio
`include "kpg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module kpg_top
  import kpg_pkg::*;
#(
  parameter int SCAN_CYC = `KPG_SCAN_CYC,
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  input wire logic [17:0] pin_i,
  output logic [17:0] pin_o,
  output logic [17:0] pin_oe_o,
  output logic [17:0] pullup_en_o,
  input wire logic [17:0] kp_sel_i,
  input wire logic [17:0] input_change_flag_en_i,
  input wire logic [17:0] gpi_evt_en_i,
  input wire logic [17:0] gpio_dout_i,
  input wire logic reset_pin_i,
  output logic hw_reset_o,
  input wire logic locked_i,
  input wire logic lock_start_i,
  input wire logic queue_full_i,
  input wire logic queue_pending_i,
  output logic evt_valid_o,
  output logic [7:0] evt_code_o,
  output logic queue_wrap_en_o
);
  // ************************************************************
  // constants and checks
  // ************************************************************
  localparam int DEB_CYC = `KPG_DEB_CYC;
  localparam int SETTLE = DEB_CYC + 4;
  localparam logic [10:0] DEB_LAST = 11'(DEB_CYC - 1);
  localparam logic [11:0] SETTLE_LAST = 12'(SETTLE - 1);
  localparam logic [23:0] SCAN_LAST = 24'(SCAN_CYC - 1);
  // rows share the input filter, so a column must settle past it
  if (SCAN_CYC >= 2**24 || SCAN_CYC <= 10 * SETTLE + 100) begin : g_bad_scan
    $error("scan period cannot hold a full column sweep");
  end
  if (DEB_CYC > 2047) begin : g_bad_deb
    $error("debounce count too wide");
  end

  kpg_state_t st;
  kpg_state_t n;
  logic [17:0] gtrig;

  function automatic logic [7:0] rd_reg(input kpg_state_t s);
    unique case (s.ptr)
      `KPG_OFS_CFG: rd_reg = s.cfg;
      `KPG_OFS_FLAGS: rd_reg = {3'h0, s.flags};
      `KPG_OFS_DIR_ROWS: rd_reg = s.dir[7:0];
      `KPG_OFS_DIR_CLO: rd_reg = s.dir[15:8];
      `KPG_OFS_DIR_CHI: rd_reg = {6'h00, s.dir[17:16]};
      `KPG_OFS_POL_ROWS: rd_reg = s.pol[7:0];
      `KPG_OFS_POL_CLO: rd_reg = s.pol[15:8];
      `KPG_OFS_POL_CHI: rd_reg = {6'h00, s.pol[17:16]};
      `KPG_OFS_BYP_ROWS: rd_reg = s.byp[7:0];
      `KPG_OFS_BYP_CLO: rd_reg = s.byp[15:8];
      `KPG_OFS_BYP_CHI: rd_reg = {6'h00, s.byp[17:16]};
      `KPG_OFS_PULL_ROWS: rd_reg = s.pull[7:0];
      `KPG_OFS_PULL_CLO: rd_reg = s.pull[15:8];
      `KPG_OFS_PULL_CHI: rd_reg = {6'h00, s.pull[17:16]};
      default: rd_reg = 8'h00;
    endcase
  endfunction : rd_reg

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    logic tick;
    logic scl_rise;
    logic scl_fall;
    logic wr_en;
    logic [7:0] clr;
    logic push;
    logic [7:0] code;
    logic mute;
    logic cad_now;
    logic rows_low;
    logic [7:0] nb;
    tick = 1'b0;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    wr_en = 1'b0;
    clr = 8'h00;
    push = 1'b0;
    code = 8'h00;
    mute = 1'b0;
    cad_now = 1'b0;
    rows_low = 1'b0;
    nb = 8'h00;
    n = st;
    gtrig = 18'h00000;

    // i2c target: start/stop win over bit traffic
    scl_rise = scl_i & ~st.scl_q;
    scl_fall = ~scl_i & st.scl_q;
    n.scl_q = scl_i;
    n.sda_q = sda_i;
    if (st.scl_q && scl_i && st.sda_q && !sda_i) begin
      n.i2c = I2C_ADDR;
      n.bcnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (st.scl_q && scl_i && !st.sda_q && sda_i) begin
      n.i2c = I2C_IDLE;
      n.sda_oe = 1'b0;
    end else if (scl_rise) begin
      // the host's ack bit after a read byte must land in sh[0] for the rack decision
      if (st.i2c == I2C_ADDR || st.i2c == I2C_WR || st.i2c == I2C_RD ||
          st.i2c == I2C_RACK) begin
        n.sh = {st.sh[6:0], sda_i};
        n.bcnt = st.bcnt + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (st.i2c)
        I2C_ADDR:
          if (st.bcnt == 4'h8) begin
            if (st.sh[7:1] == DEV_ADDR) begin
              n.sda_oe = 1'b1;
              n.rw = st.sh[0];
              n.i2c = I2C_ACK_A;
            end else begin
              n.i2c = I2C_IDLE;
            end
          end
        I2C_ACK_A: begin
          n.bcnt = 4'h0;
          n.first = 1'b1;
          if (st.rw) begin
            nb = rd_reg(st);
            n.rsh = {nb[6:0], 1'b0};
            n.sda_oe = ~nb[7];
            n.i2c = I2C_RD;
          end else begin
            n.sda_oe = 1'b0;
            n.i2c = I2C_WR;
          end
        end
        I2C_WR:
          if (st.bcnt == 4'h8) begin
            n.sda_oe = 1'b1;
            n.i2c = I2C_ACK_W;
            n.first = 1'b0;
            if (st.first) begin
              n.ptr = st.sh;
            end else begin
              wr_en = 1'b1;
              if (st.cfg[`KPG_CFG_STEP]) n.ptr = st.ptr + 8'h01;
            end
          end
        I2C_ACK_W: begin
          n.sda_oe = 1'b0;
          n.bcnt = 4'h0;
          n.i2c = I2C_WR;
        end
        I2C_RD:
          if (st.bcnt == 4'h8) begin
            n.sda_oe = 1'b0;
            n.i2c = I2C_RACK;
            if (st.cfg[`KPG_CFG_STEP]) n.ptr = st.ptr + 8'h01;
          end else begin
            n.sda_oe = ~st.rsh[7];
            n.rsh = {st.rsh[6:0], 1'b0};
          end
        I2C_RACK:
          if (st.sh[0]) begin
            n.i2c = I2C_IDLE;
          end else begin
            nb = rd_reg(st);
            n.rsh = {nb[6:0], 1'b0};
            n.sda_oe = ~nb[7];
            n.bcnt = 4'h0;
            n.i2c = I2C_RD;
          end
        default: n.i2c = I2C_IDLE;
      endcase
    end

    // register writes; reserved bits of third banks are not stored
    if (wr_en) begin
      unique case (st.ptr)
        `KPG_OFS_CFG: n.cfg = st.sh;
        `KPG_OFS_FLAGS: clr = st.sh;
        `KPG_OFS_DIR_ROWS: n.dir[7:0] = st.sh;
        `KPG_OFS_DIR_CLO: n.dir[15:8] = st.sh;
        `KPG_OFS_DIR_CHI: n.dir[17:16] = st.sh[1:0];
        `KPG_OFS_POL_ROWS: n.pol[7:0] = st.sh;
        `KPG_OFS_POL_CLO: n.pol[15:8] = st.sh;
        `KPG_OFS_POL_CHI: n.pol[17:16] = st.sh[1:0];
        `KPG_OFS_BYP_ROWS: n.byp[7:0] = st.sh;
        `KPG_OFS_BYP_CLO: n.byp[15:8] = st.sh;
        `KPG_OFS_BYP_CHI: n.byp[17:16] = st.sh[1:0];
        `KPG_OFS_PULL_ROWS: n.pull[7:0] = st.sh;
        `KPG_OFS_PULL_CLO: n.pull[15:8] = st.sh;
        `KPG_OFS_PULL_CHI: n.pull[17:16] = st.sh[1:0];
        default: clr = 8'h00;
      endcase
    end

    // ************************************************************
    // input filters
    // ************************************************************
    mute = locked_i & st.cfg[`KPG_CFG_LOCKSEL];
    for (int i = 0; i < 18; i++) begin
      if (st.byp[i] || pin_i[i] == st.deb[i]) begin
        n.deb[i] = pin_i[i];
        n.dcnt[i] = 11'h000;
      end else if (st.dcnt[i] == DEB_LAST) begin
        n.deb[i] = pin_i[i];
        n.dcnt[i] = 11'h000;
      end else begin
        n.dcnt[i] = st.dcnt[i] + 11'h001;
      end
      if (!kp_sel_i[i] && !st.dir[i] && !mute && n.deb[i] != st.deb[i]) begin
        gtrig[i] = input_change_flag_en_i[i] & (n.deb[i] == st.pol[i]);
        if (gpi_evt_en_i[i]) n.gpend[i] = 1'b1;
      end
    end
    // reset pin ignores the bypass bits
    if (reset_pin_i == st.rdeb) begin
      n.rcnt = 11'h000;
    end else if (st.rcnt == DEB_LAST) begin
      n.rdeb = reset_pin_i;
      n.rcnt = 11'h000;
    end else begin
      n.rcnt = st.rcnt + 11'h001;
    end

    // ************************************************************
    // keypad sweep
    // ************************************************************
    tick = (st.tcnt == SCAN_LAST);
    n.tcnt = tick ? 24'h000000 : st.tcnt + 24'h000001;
    rows_low = |(~st.deb[7:0] & kp_sel_i[7:0]);
    unique case (st.scan)
      SC_IDLE:
        if (rows_low) begin
          n.scan = SC_COL;
          n.col = 4'h0;
          n.scnt = 12'h000;
          n.cur = 80'h0;
        end
      SC_COL:
        if (st.scnt == SETTLE_LAST) begin
          for (int r = 0; r < 8; r++) begin
            n.cur[r * 10 + int'(st.col)] = kp_sel_i[r] & kp_sel_i[8 + int'(st.col)] &
              ~st.deb[r];
          end
          n.scnt = 12'h000;
          if (st.col == 4'h9) n.scan = SC_CMP;
          else n.col = st.col + 4'h1;
        end else begin
          n.scnt = st.scnt + 12'h001;
        end
      SC_CMP: begin
        n.prev = st.cur;
        n.widx = 7'h00;
        if (st.cur == st.prev && st.cur != st.acc) n.scan = SC_WALK;
        else if (st.cur == 80'h0 && st.acc == 80'h0) n.scan = SC_IDLE;
        else n.scan = SC_WAIT;
      end
      SC_WALK: begin
        if (st.acc[st.widx] != st.prev[st.widx]) begin
          push = 1'b1;
          code = {st.prev[st.widx], st.widx + 7'h01};
          n.acc[st.widx] = st.prev[st.widx];
        end
        if (st.widx == 7'd79) n.scan = SC_WAIT;
        else n.widx = st.widx + 7'h01;
      end
      SC_WAIT:
        if (tick) begin
          n.scan = SC_COL;
          n.col = 4'h0;
          n.scnt = 12'h000;
          n.cur = 80'h0;
        end
      default: n.scan = SC_IDLE;
    endcase
    // pending input events go out only between key events
    if (!push) begin
      for (int i = 17; i >= 0; i--) begin
        if (st.gpend[i]) begin
          push = 1'b1;
          code = {st.deb[i] == st.pol[i], `KPG_GPI_CODE_BASE + 7'(i)};
        end
      end
      for (int i = 0; i < 18; i++) begin
        if (code[6:0] == `KPG_GPI_CODE_BASE + 7'(i) && push) n.gpend[i] = 1'b0;
      end
    end

    // ************************************************************
    // flags and alert; clears first so that a same-cycle set wins
    // ************************************************************
    if (clr[`KPG_FLG_KEY] && queue_pending_i) clr[`KPG_FLG_KEY] = 1'b0;
    n.flags = st.flags & ~clr[4:0];
    n.evt_v = 1'b0;
    if (push) begin
      if (!queue_full_i || st.cfg[`KPG_CFG_WRAP]) begin
        n.evt_v = 1'b1;
        n.evt_code = code;
        n.flags[`KPG_FLG_KEY] = 1'b1;
        if (queue_full_i && st.cfg[`KPG_CFG_OVR_EN]) n.flags[`KPG_FLG_OVR] = 1'b1;
      end
    end
    if (|gtrig) n.flags[`KPG_FLG_GPI] = 1'b1;
    if (lock_start_i) n.flags[`KPG_FLG_LOCK] = 1'b1;
    cad_now = n.acc[0] & n.acc[10] & n.acc[20];
    n.cad_q = cad_now;
    if (cad_now && !st.cad_q) n.flags[`KPG_FLG_CAD] = 1'b1;
    if (|clr[4:0] && st.cfg[`KPG_CFG_REALERT] && (queue_pending_i || |st.gpend)) begin
      n.hold = DEB_LAST;
    end else if (st.hold != 11'h000) begin
      n.hold = st.hold - 11'h001;
    end
    // disabled overrun and lock flags never pull the alert
    n.int_n = ~((st.flags[`KPG_FLG_CAD] | st.flags[`KPG_FLG_GPI] | st.flags[`KPG_FLG_KEY] |
      (st.flags[`KPG_FLG_OVR] & st.cfg[`KPG_CFG_OVR_EN] & st.cfg[`KPG_CFG_WRAP]) |
      (st.flags[`KPG_FLG_LOCK] & st.cfg[`KPG_CFG_LOCK_EN])) & st.hold == 11'h000);

    // ************************************************************
    // pin control
    // ************************************************************
    for (int i = 0; i < 18; i++) begin
      n.pin_oe[i] = kp_sel_i[i] ? 1'b0 : st.dir[i];
      n.pin_out[i] = kp_sel_i[i] ? 1'b0 : gpio_dout_i[i];
      n.pull_en[i] = ~st.pull[i];
    end
    for (int c = 0; c < 10; c++) begin
      if (kp_sel_i[8 + c]) begin
        n.pin_oe[8 + c] = (st.scan == SC_COL) ? (int'(st.col) == c) : 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.i2c <= I2C_IDLE;
      st.scan <= SC_IDLE;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.rdeb <= 1'b1;
      st.deb <= 18'h3FFFF;
      st.cfg <= `KPG_CFG_RST;
      st.flags <= `KPG_FLG_RST;
      st.dir <= `KPG_BANK_RST;
      st.pol <= `KPG_BANK_RST;
      st.byp <= `KPG_BANK_RST;
      st.pull <= `KPG_BANK_RST;
      st.int_n <= 1'b1;
      st.pull_en <= 18'h3FFFF;
    end else begin
      st <= n;
    end
  end

  assign sda_o = 1'b0 & st.sda_q;
  assign sda_oe_o = st.sda_oe;
  assign int_n_o = st.int_n;
  assign pin_o = st.pin_out;
  assign pin_oe_o = st.pin_oe;
  assign pullup_en_o = st.pull_en;
  assign hw_reset_o = ~st.rdeb;
  assign evt_valid_o = st.evt_v;
  assign evt_code_o = st.evt_code;
  assign queue_wrap_en_o = st.cfg[`KPG_CFG_WRAP];

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_dir_drive: assert property (pin_oe_o[0] |-> $past(st.dir[0] && !kp_sel_i[0]))
    else $error("row pin driven without output direction");
  chk_pol_trigger: assert property ($rose(st.flags[1]) |-> $past(|gtrig))
    else $error("input flag set without polarity trigger");
  chk_bypass_follow: assert property (st.byp[2] && !$past(st.byp[2]) ##0 st.byp[2] |=>
    st.deb[2] == $past(pin_i[2]))
    else $error("bypassed input not following pin");
  chk_reset_filter: assert property ($changed(st.rdeb) |-> $past(st.rcnt) == DEB_LAST)
    else $error("reset input changed before 50 us");
  chk_deb_stable: assert property (!$past(st.byp[1]) && $changed(st.deb[1]) |->
    $past(st.dcnt[1]) == DEB_LAST)
    else $error("input filter released early");
  chk_scan_tick: assert property (st.scan == SC_WAIT ##1 st.scan == SC_COL |->
    $past(st.tcnt) == SCAN_LAST)
    else $error("sweep started off the scan period");
  chk_two_scans: assert property ($rose(st.scan == SC_WALK) |-> $past(st.cur == st.prev))
    else $error("keys accepted without two matching scans");
  chk_ovr_gate: assert property ($rose(st.flags[3]) |-> $past(st.cfg[3] && st.cfg[5]))
    else $error("overrun flag without both enables");
  chk_alert_hold: assert property (st.hold != 11'h000 |=> int_n_o)
    else $error("alert asserted during release window");
  chk_cad_combo: assert property ($rose(st.flags[4]) |-> st.acc[0] && st.acc[10] &&
    st.acc[20])
    else $error("three-key flag without keys 1, 11, 21");
  chk_col_one: assert property (st.scan == SC_COL |=> $countones(pin_oe_o[17:8] &
    kp_sel_i[17:8]) <= 1)
    else $error("more than one column swept at once");
  cov_key_event: cover property (st.scan == SC_WALK && evt_valid_o);
  cov_overrun: cover property ($rose(st.flags[3]));
  cov_realert: cover property ($rose(st.hold != 11'h000));
  cov_i2c_read: cover property (st.i2c == I2C_RACK ##1 st.i2c == I2C_RD);
endmodule : kpg_top
`default_nettype wire

// [sim/kpg_host.sv]
// i2c host model: clocks scl and pulls sda low, reads back bytes.
// assumes the bench resolves the sda wire from both pull-downs.
`timescale 1ns/1ps
`default_nettype none
module kpg_host #(
  parameter logic [6:0] ADDR = 7'h2A // arbitrary bus address
)(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // ****
  // bus cycles
  // ****
  logic [7:0] rd_byte;
  int miss = 0;
  event rd_ev;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tk
  // sda only moves while scl is low, so no false start or stop
  task automatic bt(input logic b, output logic s);
    sda_low_o = ~b;
    tk(1);
    scl_o = 1'b1;
    tk(2);
    s = sda_i;
    tk(1);
    scl_o = 1'b0;
    tk(1);
  endtask : bt
  task automatic sb(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
      bt(v[i], s);
    bt(1'b1, s);
    if (s !== 1'b0)
      miss++;
  endtask : sb
  task automatic go(input logic [7:0] a);
    sda_low_o = 1'b0;
    tk(1);
    scl_o = 1'b1;
    tk(2);
    sda_low_o = 1'b1;
    tk(2);
    scl_o = 1'b0;
    tk(1);
    sb(a);
  endtask : go
  task automatic stop();
    sda_low_o = 1'b1;
    tk(1);
    scl_o = 1'b1;
    tk(2);
    sda_low_o = 1'b0;
    tk(2);
  endtask : stop
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    go({ADDR, 1'b0});
    sb(p);
    foreach (d[i])
      sb(d[i]);
    stop();
  endtask : wr
  // host fetches each byte at once, never letting results pile up
  task automatic rd(input logic [7:0] p, input int n);
    logic s;
    go({ADDR, 1'b0});
    sb(p);
    go({ADDR, 1'b1});
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bt(1'b1, s);
        rd_byte[i] = s;
      end
      ->rd_ev;
      bt(k == n - 1, s);
    end
    stop();
  endtask : rd
endmodule : kpg_host
`default_nettype wire

// [sim/tb_kpg_top.sv]
// self-checking bench of kpg_top: i2c host model, gpio pads, one matrix key.
// assumes the scan period is shortened through SCAN_CYC.
`include "kpg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_kpg_top;
  // ****
  // harness
  // ****
  localparam int SCAN = 20300;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reset_pin_i = 1'b1;
  logic kp_press = 1'b0;
  logic lock_start_i = 1'b0, locked_i = 1'b0, queue_full_i = 1'b0, queue_pending_i = 1'b0;
  logic [17:0] gdrv = '1, kp_sel_i = '0, input_change_flag_en_i = '0, gpi_evt_en_i = '0, gpio_dout_i = '0;
  logic scl, sda_low, sda_oe_o, int_n_o, hw_reset_o, evt_valid_o, queue_wrap_en_o;
  logic [17:0] pin_o, pin_oe_o, pullup_en_o;
  logic [7:0] evt_code_o, d, m;
  wire logic sda_w = ~(sda_low | sda_oe_o);
  // row 0 follows column 0 through the pressed key, else pulled up
  wire logic [17:0] pin_w = {gdrv[17:1], kp_press ? (pin_oe_o[8] ? pin_o[8] : 1'b1) : gdrv[0]};
  int num_errors = 0, cmp_count = 0, cyc = 0;
  logic [8:0] eq[$];
  logic [7:0] rq[$];
  logic [7:0] ofs[14] = '{`KPG_OFS_CFG, `KPG_OFS_DIR_ROWS, `KPG_OFS_DIR_CLO, `KPG_OFS_DIR_CHI,
    `KPG_OFS_POL_ROWS, `KPG_OFS_POL_CLO, `KPG_OFS_POL_CHI, `KPG_OFS_BYP_ROWS, `KPG_OFS_BYP_CHI,
    `KPG_OFS_PULL_ROWS, `KPG_OFS_PULL_CHI, `KPG_OFS_BYP_CLO, `KPG_OFS_PULL_CLO, 8'h50};
  always #12.5 clk_i = ~clk_i;
  kpg_host kpg_host_i (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));
  kpg_top #(.SCAN_CYC(SCAN)) kpg_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o), .kp_sel_i(kp_sel_i),
    .input_change_flag_en_i(input_change_flag_en_i), .gpi_evt_en_i(gpi_evt_en_i), .gpio_dout_i(gpio_dout_i),
    .reset_pin_i(reset_pin_i), .hw_reset_o(hw_reset_o), .locked_i(locked_i),
    .lock_start_i(lock_start_i), .queue_full_i(queue_full_i), .queue_pending_i(queue_pending_i),
    .evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o), .queue_wrap_en_o(queue_wrap_en_o));
  // ****
  // checks
  // ****
  task automatic bad(input logic [17:0] g, input logic [17:0] e);
    num_errors++;
    $display("BAD %0t got %h exp %h", $time, g, e);
  endtask : bad
  task automatic cmp_val(input logic [17:0] g, input logic [17:0] e);
    cmp_count++;
    if (g !== e)
      bad(g, e);
  endtask : cmp_val
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
      bad(g, e);
  endtask : cmp_rd
  // bit 8 of a note means the press bit is not judged
  task automatic cmp_evt(input logic [7:0] g, input logic [8:0] e);
    cmp_count++;
    if ((e[8] === 1'b1) ? (g[6:0] !== e[6:0]) : (g !== e[7:0]))
      bad(g, e);
  endtask : cmp_evt
  always @(kpg_host_i.rd_ev)
    cmp_rd(kpg_host_i.rd_byte, (rq.size() > 0) ? rq.pop_front() : 'x);
  always @(negedge clk_i)
    if (evt_valid_o === 1'b1)
      cmp_evt(evt_code_o, (eq.size() > 0) ? eq.pop_front() : 'x);
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 100000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  // ****
  // helpers
  // ****
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tk
  task automatic w(input logic [7:0] a, input logic [7:0] v);
    kpg_host_i.wr(a, '{v});
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    kpg_host_i.rd(a, 1);
  endtask : r
  task automatic wait_evt(input int n);
    for (int i = 0; i < n && eq.size() > 0; i++)
      tk(1);
    cmp_val(18'(eq.size()), 18'h0);
  endtask : wait_evt
  // ****
  // tests
  // ****
  initial
  begin
    d = 8'($urandom(58));
    tk(20);
    rst_n_i = 1'b1;
    tk(2);
    cmp_val(pin_oe_o, 18'h0);
    cmp_val(pullup_en_o, '1);
    r(`KPG_OFS_FLAGS, 8'h00);
    foreach (ofs[i])
    begin
      m = (ofs[i] inside {`KPG_OFS_DIR_CHI, `KPG_OFS_POL_CHI, `KPG_OFS_BYP_CHI,
        `KPG_OFS_PULL_CHI}) ? 8'h03 : ((i == 13) ? 8'h00 : 8'hFF);
      d = 8'($urandom);
      r(ofs[i], 8'h00);
      w(ofs[i], d);
      r(ofs[i], d & m);
      w(ofs[i], 8'h00);
    end
    $display("%0t test registers done", $time);
    gpio_dout_i = 18'($urandom);
    w(`KPG_OFS_DIR_ROWS, 8'hA5);
    w(`KPG_OFS_PULL_ROWS, 8'h3C);
    tk(3);
    cmp_val(pin_oe_o, 18'h000A5);
    cmp_val(pin_o & 18'hA5, gpio_dout_i & 18'hA5);
    cmp_val(pullup_en_o, ~18'h3C);
    w(`KPG_OFS_CFG, 8'hA0);
    tk(3);
    cmp_val(queue_wrap_en_o, 1'b1);
    kpg_host_i.wr(`KPG_OFS_DIR_ROWS, '{8'h00, 8'h00});
    kpg_host_i.wr(`KPG_OFS_PULL_CLO, '{8'h11, 8'h22});
    rq.push_back(8'h11);
    rq.push_back(8'h00);
    kpg_host_i.rd(`KPG_OFS_PULL_CLO, 2);
    w(`KPG_OFS_CFG, 8'h20);
    kpg_host_i.wr(`KPG_OFS_POL_ROWS, '{8'h33, 8'h44});
    r(`KPG_OFS_POL_ROWS, 8'h44);
    r(`KPG_OFS_POL_CLO, 8'h00);
    w(`KPG_OFS_POL_ROWS, 8'h00);
    w(`KPG_OFS_PULL_ROWS, 8'h00);
    w(`KPG_OFS_CFG, 8'h00);
    $display("%0t test config done", $time);
    input_change_flag_en_i[9] = 1'b1;
    w(`KPG_OFS_BYP_CLO, 8'h02);
    for (int p = 0; p < 2; p++)
    begin
      w(`KPG_OFS_POL_CLO, {6'h00, p[0], 1'b0});
      gdrv[9] = ~p[0];
      tk(4);
      w(`KPG_OFS_FLAGS, 8'h1F);
      tk(4);
      cmp_val(int_n_o, 1'b1);
      gdrv[9] = p[0];
      tk(4);
      cmp_val(int_n_o, 1'b0);
      r(`KPG_OFS_FLAGS, 8'h02);
    end
    w(`KPG_OFS_FLAGS, 8'h02);
    tk(3);
    cmp_val(int_n_o, 1'b1);
    w(`KPG_OFS_CFG, 8'h40);
    locked_i = 1'b1;
    gdrv[9] = 1'b0;
    tk(2);
    gdrv[9] = 1'b1;
    tk(4);
    cmp_val(int_n_o, 1'b1);
    locked_i = 1'b0;
    w(`KPG_OFS_CFG, 8'h00);
    gpi_evt_en_i[10] = 1'b1;
    gdrv[10] = 1'b0;
    tk(1990);
    gdrv[10] = 1'b1;
    tk(2100);
    eq.push_back(9'h16B);
    gdrv[10] = 1'b0;
    tk(1990);
    cmp_val(18'(eq.size()), 18'h1);
    wait_evt(200);
    queue_pending_i = 1'b1;
    w(`KPG_OFS_CFG, 8'h10);
    w(`KPG_OFS_FLAGS, 8'h1F);
    tk(3);
    cmp_val(int_n_o, 1'b1);
    tk(2000);
    cmp_val(int_n_o, 1'b0);
    r(`KPG_OFS_FLAGS, 8'h01);
    queue_pending_i = 1'b0;
    queue_full_i = 1'b1;
    w(`KPG_OFS_CFG, 8'h08);
    w(`KPG_OFS_FLAGS, 8'h1F);
    w(`KPG_OFS_BYP_CLO, 8'h06);
    gdrv[10] = 1'b1;
    tk(4);
    r(`KPG_OFS_FLAGS, 8'h00);
    w(`KPG_OFS_CFG, 8'h28);
    eq.push_back(9'h16B);
    gdrv[10] = 1'b0;
    wait_evt(8);
    r(`KPG_OFS_FLAGS, 8'h09);
    queue_full_i = 1'b0;
    w(`KPG_OFS_FLAGS, 8'h1F);
    w(`KPG_OFS_CFG, 8'h00);
    $display("%0t test inputs done", $time);
    reset_pin_i = 1'b0;
    tk(1990);
    cmp_val(hw_reset_o, 1'b0);
    tk(20);
    cmp_val(hw_reset_o, 1'b1);
    reset_pin_i = 1'b1;
    lock_start_i = 1'b1;
    tk(1);
    lock_start_i = 1'b0;
    tk(3);
    cmp_val(int_n_o, 1'b1);
    r(`KPG_OFS_FLAGS, 8'h04);
    w(`KPG_OFS_CFG, 8'h04);
    tk(3);
    cmp_val(int_n_o, 1'b0);
    w(`KPG_OFS_FLAGS, 8'h04);
    tk(3);
    cmp_val(int_n_o, 1'b1);
    w(`KPG_OFS_CFG, 8'h00);
    $display("%0t test reset and lock done", $time);
    kp_sel_i = 18'h00101;
    tk(4);
    cmp_val({pin_oe_o[8], pin_o[8]}, 18'h2);
    kp_press = 1'b1;
    eq.push_back(9'h081);
    tk(30000);
    cmp_val(18'(eq.size()), 18'h1);
    wait_evt(40000);
    r(`KPG_OFS_FLAGS, 8'h01);
    cmp_val(18'(kpg_host_i.miss), 18'h0);
    $display("%0t test keypad done", $time);
    give_verdict();
  end
endmodule : tb_kpg_top
`default_nettype wire
